// file: dwfd_pkg.sv
/*
  Constants, register map and carrier types of the desat window fault detector.
  Assumes a 250 MHz ref_clk and an AHB-Lite master doing single word transfers.
*/
// Behaviour
// - Four window boundary times from PWM turn-on, meant for zero to 50 us.
// - Timers take up to 1.31 ms; window boundary settings over 50 us are flagged.
// - Three collector monitor comparator inputs, each with own threshold.
// - Each collector monitor has a 4-bit mask; bit n enables window n.
// - Desat diode comparator threshold is settable.
// - Desat diode comparator has its own 4-bit window mask.
// - Second desat comparator has separate threshold and mask.
// - Comparators qualified by active window bit, ORed into raw fault.
// - Fault reported only when raw fault is high longer than filter time.
// - Filter time programmable from zero to 5 us.
// - Fault within 10 us of turn-on is type 1, later is type 2.
// - Simplified mode: single comparator, fixed level, programmable detect time.
// - Simplified mode monitors from first detection time after gate high.
// - Simplified mode second detection time only splits type 1 from type 2.
// - Type 2 faults wait a programmable delay from fault before turn-off.
// - Confirmed fault drives feedback low and turns off unless disabled.
// - After a fault the gate stays off for the programmed inhibit time.
package dwfd_pkg;
  localparam int CLK_MHZ = 250;
  localparam int TICK_NS = 20;
  localparam logic [2:0] TICK_CYC = 3'(TICK_NS * CLK_MHZ / 1000);
  localparam int TYPE1_US = 10;
  localparam logic [15:0] TYPE1_TICKS = 16'(TYPE1_US * 1000 / TICK_NS);
  localparam int WIN_MAX_US = 50;
  localparam logic [15:0] WIN_MAX_TICKS = 16'(WIN_MAX_US * 1000 / TICK_NS);
  // register word addresses
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_WIN0 = 6'h01;
  localparam logic [5:0] A_MASK = 6'h05;
  localparam logic [5:0] A_THR0 = 6'h06;
  localparam logic [5:0] A_THR1 = 6'h07;
  localparam logic [5:0] A_FILT = 6'h08;
  localparam logic [5:0] A_DLY = 6'h09;
  localparam logic [5:0] A_INH = 6'h0A;
  localparam logic [5:0] A_SDT1 = 6'h0B;
  localparam logic [5:0] A_SDT2 = 6'h0C;
  localparam logic [5:0] A_STAT = 6'h0D;
  // control bits
  localparam int B_SIMPLE = 0;
  localparam int B_NOOFF = 1;
  localparam int B_CLR = 2;
  localparam int NCMP = 5;
  localparam int NWIN = 4;
  // comparator order: desat1, desat2, vce1, vce2, vce3
  typedef struct packed {
    logic [2:0] vce;
    logic [1:0] desat;
  } dwfd_cmp_t;
  typedef struct packed {
    logic [7:0] vce3;
    logic [7:0] vce2;
    logic [7:0] vce1;
    logic [7:0] desat2;
    logic [7:0] desat1;
  } dwfd_thr_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ON, ST_DELAY, ST_HOLD, ST_INHIB} dwfd_st_t;
endpackage

// file: dwfd_top.sv
/*
  Desat window fault detector: window timing, comparator qualification,
  noise filter, type 1/2 classing, turn-off delay and inhibit, AHB-Lite regs.
  Assumes comparator outputs and pwm_cmd are synchronous to ref_clk.
*/
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module dwfd_top (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // power stage side
  input  wire logic               pwm_cmd,
  input  wire dwfd_pkg::dwfd_cmp_t cmp_in,
  output dwfd_pkg::dwfd_thr_t     thr_out,
  output logic                    gate_on,
  output logic                    fault_feedback_output_n
);
  import dwfd_pkg::*;

  logic [31:0] hrdata_ff;
  logic        wr_ff;
  logic [5:0]  wa_ff;
  logic [1:0]  ctrl_ff;
  logic        clr;
  logic [15:0] win_t_ff [NWIN];
  logic [19:0] mask_ff;
  dwfd_thr_t   thr_ff;
  logic [7:0]  filt_tc_ff;
  logic [15:0] dly_ff, inh_ff, sdt1_ff, sdt2_ff;
  logic [2:0]  div_ff;
  logic        tick;
  dwfd_st_t    st_ff;
  logic        pwm_q_ff;
  logic [15:0] el_ff, dly_cnt_ff, inh_cnt_ff;
  logic [8:0]  filt_cnt_ff;
  logic        t1_ff, t2_ff, gate_ff, fb_n_ff;
  logic [NWIN-1:0] ge;
  logic [1:0]  win;
  logic        win_ok, raw_fault, confirm, is_t1, warn;
  logic [NCMP-1:0] cmp, qual;
  logic        aphase;
  logic [31:0] rmux;

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1 | ~nrst;
  assign hresp     = 1'b0;
  assign thr_out   = thr_ff;
  assign gate_on   = gate_ff;
  assign fault_feedback_output_n = fb_n_ff;

  // bus address phase and write data phase
  assign aphase = hsel & htrans[1] & hready;
  assign clr = wr_ff & (wa_ff == A_CTRL) & hwdata[B_CLR];
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wr_ff <= 1'b0;
      wa_ff <= 6'h00;
    end else begin
      wr_ff <= aphase & hwrite;
      wa_ff <= haddr[7:2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_ff <= 2'h0;
      for (int i = 0; i < NWIN; i++) win_t_ff[i] <= 16'h0000;
      mask_ff <= 20'h00000;
      thr_ff <= '0;
      filt_tc_ff <= 8'h00;
      dly_ff <= 16'h0000;
      inh_ff <= 16'h0000;
      sdt1_ff <= 16'h0000;
      sdt2_ff <= 16'h0000;
    end else if (wr_ff) begin
      unique case (wa_ff)
        A_CTRL: ctrl_ff <= hwdata[1:0];
        A_MASK: mask_ff <= hwdata[19:0];
        A_THR0: thr_ff[15:0] <= hwdata[15:0];
        A_THR1: thr_ff[39:16] <= hwdata[23:0];
        A_FILT: filt_tc_ff <= hwdata[7:0];
        A_DLY: dly_ff <= hwdata[15:0];
        A_INH: inh_ff <= hwdata[15:0];
        A_SDT1: sdt1_ff <= hwdata[15:0];
        A_SDT2: sdt2_ff <= hwdata[15:0];
        default: begin
          for (int i = 0; i < NWIN; i++)
            if (wa_ff == A_WIN0 + 6'(i)) win_t_ff[i] <= hwdata[15:0];
        end
      endcase
    end
  end

  // flag boundaries beyond the recommended span
  always_comb begin
    warn = 1'b0;
    for (int i = 0; i < NWIN; i++) warn = warn | (win_t_ff[i] > WIN_MAX_TICKS);
  end

  always_comb begin
    rmux = 32'h00000000;
    unique case (haddr[7:2])
      A_CTRL: rmux = {30'h0, ctrl_ff};
      A_MASK: rmux = {12'h000, mask_ff};
      A_THR0: rmux = {16'h0000, thr_ff[15:0]};
      A_THR1: rmux = {8'h00, thr_ff[39:16]};
      A_FILT: rmux = {24'h000000, filt_tc_ff};
      A_DLY: rmux = {16'h0000, dly_ff};
      A_INH: rmux = {16'h0000, inh_ff};
      A_SDT1: rmux = {16'h0000, sdt1_ff};
      A_SDT2: rmux = {16'h0000, sdt2_ff};
      A_STAT: rmux = {24'h000000, win_ok, win, warn, raw_fault, ~fb_n_ff, t2_ff, t1_ff};
      default: begin
        for (int i = 0; i < NWIN; i++)
          if (haddr[7:2] == A_WIN0 + 6'(i)) rmux = {16'h0000, win_t_ff[i]};
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) hrdata_ff <= 32'h00000000;
    else if (aphase & ~hwrite) hrdata_ff <= rmux;
  end

  // 20 ns time base
  assign tick = (div_ff == TICK_CYC - 3'h1);
  always_ff @(posedge ref_clk) begin
    if (!nrst) div_ff <= 3'h0;
    else div_ff <= tick ? 3'h0 : div_ff + 3'h1;
  end

  // window index from the boundary compares
  generate
    for (genvar i = 0; i < NWIN; i++) begin : g_ge
      assign ge[i] = el_ff >= win_t_ff[i];
    end
  endgenerate
  assign win_ok = ge[0];
  assign win = ge[3] ? 2'd3 : ge[2] ? 2'd2 : ge[1] ? 2'd1 : 2'd0;

  assign cmp = {cmp_in.vce, cmp_in.desat};
  generate
    for (genvar c = 0; c < NCMP; c++) begin : g_q
      assign qual[c] = cmp[c] & mask_ff[4*c + 32'(win)] & win_ok;
    end
  endgenerate

  // simplified mode uses desat1 after detection time 1
  assign raw_fault = ctrl_ff[B_SIMPLE] ? (cmp_in.desat[0] & (el_ff >= sdt1_ff)) : |qual;
  assign is_t1 = el_ff < (ctrl_ff[B_SIMPLE] ? sdt2_ff : TYPE1_TICKS);
  // raw fault held longer than the filter time
  assign confirm = (st_ff == ST_ON) & pwm_cmd & raw_fault & (filt_cnt_ff > {1'b0, filt_tc_ff});

  // filter count restarts when raw fault falls
  always_ff @(posedge ref_clk) begin
    if (!nrst) filt_cnt_ff <= 9'h000;
    else if (!raw_fault || st_ff != ST_ON) filt_cnt_ff <= 9'h000;
    else if (tick && filt_cnt_ff != 9'h1FF) filt_cnt_ff <= filt_cnt_ff + 9'h001;
  end

  // time since turn-on, saturating at the timer span
  always_ff @(posedge ref_clk) begin
    if (!nrst) el_ff <= 16'h0000;
    else if (st_ff == ST_IDLE) el_ff <= 16'h0000;
    else if (tick && el_ff != 16'hFFFF) el_ff <= el_ff + 16'h0001;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) pwm_q_ff <= 1'b0;
    else pwm_q_ff <= pwm_cmd;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) st_ff <= ST_IDLE;
    else begin
      unique case (st_ff)
        ST_IDLE: if (pwm_cmd && !pwm_q_ff) st_ff <= ST_ON;
        ST_ON: begin
          if (confirm) begin
            if (ctrl_ff[B_NOOFF]) st_ff <= ST_HOLD;
            else if (is_t1 || dly_ff == 16'h0000) st_ff <= ST_INHIB;
            else st_ff <= ST_DELAY;
          end else if (!pwm_cmd) st_ff <= ST_IDLE;
        end
        ST_DELAY: if (dly_cnt_ff >= dly_ff || !pwm_cmd) st_ff <= ST_INHIB;
        ST_HOLD: if (!pwm_cmd) st_ff <= ST_INHIB;
        ST_INHIB: if (inh_cnt_ff >= inh_ff) st_ff <= ST_IDLE;
      endcase
    end
  end

  // pure delay counted from the confirmed fault
  always_ff @(posedge ref_clk) begin
    if (!nrst) dly_cnt_ff <= 16'h0000;
    else if (st_ff != ST_DELAY) dly_cnt_ff <= 16'h0000;
    else if (tick) dly_cnt_ff <= dly_cnt_ff + 16'h0001;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) inh_cnt_ff <= 16'h0000;
    else if (st_ff != ST_INHIB) inh_cnt_ff <= 16'h0000;
    else if (tick) inh_cnt_ff <= inh_cnt_ff + 16'h0001;
  end

  // sticky fault types, a new fault beats the clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      t1_ff <= 1'b0;
      t2_ff <= 1'b0;
    end else begin
      t1_ff <= (confirm & is_t1) | (t1_ff & ~clr);
      t2_ff <= (confirm & ~is_t1) | (t2_ff & ~clr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      gate_ff <= 1'b0;
      fb_n_ff <= 1'b1;
    end else begin
      gate_ff <= pwm_cmd & (st_ff == ST_ON || st_ff == ST_DELAY || st_ff == ST_HOLD);
      fb_n_ff <= ~(st_ff == ST_DELAY || st_ff == ST_HOLD || st_ff == ST_INHIB);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_trip1;
    st_ff == ST_ON && confirm && is_t1 && !ctrl_ff[B_NOOFF];
  endsequence
  sequence s_off;
    st_ff == ST_INHIB ##1 !gate_ff && !fb_n_ff;
  endsequence

  chk_type1_trip: assert property (s_trip1 |=> s_off)
    else $error("type 1 fault did not turn off");
  chk_inhibit_off: assert property (st_ff == ST_INHIB |=> !gate_ff)
    else $error("gate on during inhibit");
  chk_filter_hold: assert property (confirm |-> $past(raw_fault, 1) && filt_cnt_ff != 9'h000)
    else $error("fault confirmed without held raw fault");
  chk_filter_rst: assert property (!raw_fault |=> filt_cnt_ff == 9'h000)
    else $error("filter count not restarted");
  chk_win_gate: assert property (!ctrl_ff[B_SIMPLE] && !win_ok |-> !raw_fault)
    else $error("raw fault outside windows");
  chk_simple_start: assert property (ctrl_ff[B_SIMPLE] && el_ff < sdt1_ff |-> !raw_fault)
    else $error("simplified mode sampled early");
  chk_type_class: assert property (confirm && !ctrl_ff[B_SIMPLE] && el_ff >= TYPE1_TICKS |=> t2_ff)
    else $error("late fault not type 2");
  chk_delay_on: assert property (st_ff == ST_DELAY && pwm_cmd |=> gate_ff && !fb_n_ff)
    else $error("gate dropped during type 2 delay");
  chk_nooff_hold: assert property (st_ff == ST_HOLD && pwm_cmd |=> gate_ff)
    else $error("gate dropped with turn-off disabled");
endmodule // dwfd_top

// file: dwfd_stage_model.sv
/*
  Behavioural power stage with its comparators: collector voltage, diode chain
  and collector monitors as seen by the detector.
  Assumes gate_on from the detector and a per-comparator short request from
  the bench; outputs change one ref_clk after their cause.
*/
`timescale 1ns/10ps
module dwfd_stage_model (
  // clock and drive
  input  wire logic                ref_clk,
  input  wire logic                gate_on,
  input  wire logic [4:0]          short_req,
  // comparator outputs
  output dwfd_pkg::dwfd_cmp_t      cmp_in
);
  import dwfd_pkg::*;
  // three monitors and two diode comparators
  // switch off means collector high, so every comparator trips
  always_ff @(posedge ref_clk) begin
    cmp_in <= gate_on ? dwfd_cmp_t'(short_req) : dwfd_cmp_t'(5'h1F);
  end
endmodule // dwfd_stage_model

// file: tb.sv
/*
  Self-checking bench of the desat window fault detector.
  Assumes zero-wait AHB-Lite slave and the stage model on the comparator side.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  import dwfd_pkg::*;
  logic        ref_clk, nrst, hsel, hwrite, pwm_cmd, hreadyout, hresp;
  logic        gate_on, fault_feedback_output_n;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0]  htrans;
  logic [4:0]  short_req;
  dwfd_cmp_t   cmp_in;
  dwfd_thr_t   thr_out;
  int          err_count, n_checks, cyc;

  dwfd_top dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_cmd(pwm_cmd), .cmp_in(cmp_in),
    .thr_out(thr_out), .gate_on(gate_on), .fault_feedback_output_n(fault_feedback_output_n));
  dwfd_stage_model stage (.ref_clk(ref_clk), .gate_on(gate_on), .short_req(short_req), .cmp_in(cmp_in));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a, 2'h0};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic wait_fb(input int n);
    int i;
    for (i = 0; i < n && fault_feedback_output_n !== 1'b0; i++) @(negedge ref_clk);
  endtask

  task automatic shot(input logic [4:0] s, input int n);
    @(posedge ref_clk);
    pwm_cmd   <= 1'b1;
    short_req <= s;
    wait_fb(n);
  endtask

  task automatic stop(input logic [1:0] typ);
    bus(1'b0, A_STAT, 32'h0);
    `CHK(rdat[1:0], typ)
    @(posedge ref_clk);
    pwm_cmd   <= 1'b0;
    short_req <= 5'h0;
    repeat (40) @(posedge ref_clk);
    bus(1'b1, A_CTRL, 32'h4);
    bus(1'b0, A_STAT, 32'h0);
    `CHK(rdat[1:0], 2'h0)
  endtask

  initial begin
    nrst = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
    pwm_cmd = 1'b0; short_req = 5'h0; err_count = 0; n_checks = 0; cyc = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    `CHK(fault_feedback_output_n, 1'b1)
    // diode thresholds kept clear of the low end
    bus(1'b1, A_THR0, 32'h0000_A55A);
    bus(1'b1, A_THR1, 32'h0033_2211);
    @(negedge ref_clk);
    `CHK(thr_out, {8'h33, 8'h22, 8'h11, 8'hA5, 8'h5A})
    bus(1'b0, A_THR0, 32'h0);
    `CHK(rdat, 32'h0000_A55A)
    bus(1'b0, 6'h3C, 32'h0);
    `CHK(rdat, 32'h0)
    `CHK(hresp, 1'b0)
    // w0 vce3, w1 vce2, w2 vce1, w3 desat1
    bus(1'b1, A_MASK, 32'h0001_2408);
    bus(1'b0, A_MASK, 32'h0);
    `CHK(rdat, 32'h0001_2408)
    bus(1'b1, A_WIN0, 32'd0);
    bus(1'b1, A_WIN0 + 6'h1, 32'd50);
    bus(1'b1, A_WIN0 + 6'h2, 32'd100);
    bus(1'b1, A_WIN0 + 6'h3, 32'd150);
    bus(1'b1, A_FILT, 32'd2);
    bus(1'b1, A_DLY, 32'd3);
    bus(1'b1, A_INH, 32'd2);
    $display("test registers done");

    // vce1 shorted, allowed only in window 2 from 500 cycles
    shot(5'h04, 300);
    `CHK(fault_feedback_output_n, 1'b1)
    wait_fb(600);
    `CHK(fault_feedback_output_n, 1'b0)
    @(negedge ref_clk);
    `CHK(gate_on, 1'b0)
    stop(2'h1);
    $display("test type 1 done");

    // desat1 from window 3 at 520 ticks, after the 10 us mark
    bus(1'b1, A_WIN0 + 6'h3, 32'd2501);
    bus(1'b0, A_STAT, 32'h0);
    `CHK(rdat[4], 1'b1)
    bus(1'b1, A_WIN0 + 6'h3, 32'd520);
    bus(1'b0, A_STAT, 32'h0);
    `CHK(rdat[4], 1'b0)
    shot(5'h01, 3000);
    `CHK(fault_feedback_output_n, 1'b0)
    `CHK(gate_on, 1'b1)
    repeat (30) @(negedge ref_clk);
    `CHK(gate_on, 1'b0)
    stop(2'h2);
    $display("test type 2 done");

    // disabled turn-off: feedback low, gate kept on while pwm high
    bus(1'b1, A_CTRL, 32'h2);
    shot(5'h10, 100);
    `CHK(fault_feedback_output_n, 1'b0)
    repeat (10) @(negedge ref_clk);
    `CHK(gate_on, 1'b1)
    stop(2'h1);
    $display("test no turn-off done");

    // simplified mode: desat1 only, detection times 20 and 30 ticks
    bus(1'b1, A_SDT1, 32'd20);
    bus(1'b1, A_SDT2, 32'd30);
    bus(1'b1, A_CTRL, 32'h1);
    shot(5'h01, 60);
    `CHK(fault_feedback_output_n, 1'b1)
    wait_fb(200);
    `CHK(fault_feedback_output_n, 1'b0)
    stop(2'h1);
    bus(1'b1, A_SDT2, 32'd10);
    bus(1'b1, A_CTRL, 32'h1);
    shot(5'h01, 300);
    `CHK(fault_feedback_output_n, 1'b0)
    stop(2'h2);
    $display("test simplified done");
    finish_test();
  end
endmodule // tb
